// *** inc/aimc_consts.svh ***
// constants for the adc input mix control registers
`ifndef AIMC_CONSTS_SVH
`define AIMC_CONSTS_SVH

`define AIMC_ADDR_W 8
`define AIMC_DATA_W 8
`define AIMC_GAIN_W 7
`define AIMC_ATTN_W 5

// register offsets
`define AIMC_OFF_AUX_MIC_RIGHT 8'h12
`define AIMC_OFF_LINE_LEFT 8'h13

// reset values
`define AIMC_RST_AUX_MIC_RIGHT 8'hff
`define AIMC_RST_LINE_LEFT 8'h78
`define AIMC_RST_GAIN 7'h00
`define AIMC_RST_ATTN 5'h00

// aux mic register fields
`define AIMC_AUXL_HI 7
`define AIMC_AUXL_LO 4
`define AIMC_AUXR_HI 3
`define AIMC_AUXR_LO 0

// line input register fields
`define AIMC_DIFF_BIT 7
`define AIMC_LINE_HI 6
`define AIMC_LINE_LO 3
`define AIMC_PWR_BIT 2
`define AIMC_STEP_HI 1
`define AIMC_STEP_LO 0

// level field codes
`define AIMC_LVL_OFF 4'hf
`define AIMC_LVL_MAX 4'h8
`define AIMC_LVL_HALF_DB_PER_CODE 5'h03

// soft-step rate codes
`define AIMC_STEP_EVERY_FS 2'h0
`define AIMC_STEP_EVERY_2FS 2'h1

`endif

// *** inc/aimc_pkg.sv ***
// types for the adc input mix control registers
package aimc_pkg;

  typedef enum logic [1:0] {
    AIMC_STEP_FS,
    AIMC_STEP_2FS,
    AIMC_STEP_OFF
  } aimc_step_t;

endpackage

// *** rtl/aimc_gain_step.sv ***
// left adc gain stage soft-stepping toward the programmed gain
`include "aimc_consts.svh"

module aimc_gain_step #(
  parameter int GAIN_W = `AIMC_GAIN_W
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [GAIN_W-1:0] target_gain,
  input wire aimc_pkg::aimc_step_t step_mode,
  input wire logic fs_tick,
  output logic [GAIN_W-1:0] gain_ff
);

  logic half_ff;
  logic step_now;

  // every fs tick, or every second one
  always_comb begin
    case (step_mode)
      aimc_pkg::AIMC_STEP_FS: step_now = fs_tick;
      aimc_pkg::AIMC_STEP_2FS: step_now = fs_tick & half_ff;
      default: step_now = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      half_ff <= 1'b0;
    end else if (step_mode != aimc_pkg::AIMC_STEP_2FS) begin
      half_ff <= 1'b0;
    end else if (fs_tick) begin
      half_ff <= ~half_ff;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      gain_ff <= `AIMC_RST_GAIN;
    end else if (step_mode == aimc_pkg::AIMC_STEP_OFF) begin
      gain_ff <= target_gain;
    end else if (step_now && gain_ff < target_gain) begin
      gain_ff <= gain_ff + GAIN_W'(1);
    end else if (step_now && gain_ff > target_gain) begin
      gain_ff <= gain_ff - GAIN_W'(1);
    end
  end

endmodule

// *** rtl/aimc_regs.sv ***
// adc input mix control register pair with left gain soft-stepping
`include "aimc_consts.svh"

// a read and a write to one offset in the same cycle return the old value
// reserved level codes are kept as written and decode as joined at 0 dB
module aimc_regs #(
  parameter int ADDR_W = `AIMC_ADDR_W,
  parameter int DATA_W = `AIMC_DATA_W,
  parameter int GAIN_W = `AIMC_GAIN_W
) (
  input wire logic ref_clk,
  input wire logic sys_rst,

  // host register access
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata_ff,

  // left gain stage soft-stepping
  input wire logic [GAIN_W-1:0] left_gain_target,
  input wire logic fs_tick,
  output logic [GAIN_W-1:0] left_gain_applied_ff,

  // mixer routing decoded from the registers
  output logic aux_mic_left_input_conn_ff,
  output logic [`AIMC_ATTN_W-1:0] aux_mic_left_input_attn_ff,
  output logic aux_mic_right_input_conn_ff,
  output logic [`AIMC_ATTN_W-1:0] aux_mic_right_input_attn_ff,
  output logic first_line_left_input_conn_ff,
  output logic [`AIMC_ATTN_W-1:0] first_line_left_input_attn_ff,
  output logic first_line_left_input_diff_ff,
  output logic left_adc_power_ff
);

  // register storage
  logic [DATA_W-1:0] aux_mic_to_right_adc_mix_ff;
  logic [DATA_W-1:0] line_in_left_adc_mix_power_ff;
  logic [DATA_W-1:0] nxt_rdata;
  // strobes qualified by the addressed register
  logic wr_aux_mic;
  logic wr_line;
  logic rd_aux_mic;
  logic rd_line;
  // field codes and rate picked out of the registers
  aimc_pkg::aimc_step_t step_mode;
  logic [3:0] auxl_code;
  logic [3:0] auxr_code;
  logic [3:0] line_code;
  logic [1:0] step_code;

  // attenuation in half-dB units, 1.5 dB per code
  function automatic logic [`AIMC_ATTN_W-1:0] lvl_attn(input logic [3:0] code);
    logic [`AIMC_ATTN_W-1:0] ext;
    ext = {1'b0, code};
    if (code > `AIMC_LVL_MAX) begin
      lvl_attn = `AIMC_RST_ATTN;
    end else begin
      lvl_attn = `AIMC_ATTN_W'(ext * `AIMC_LVL_HALF_DB_PER_CODE);
    end
  endfunction

  // an input joins its mixer for any code but the disconnect code
  function automatic logic lvl_conn(input logic [3:0] code);
    lvl_conn = (code != `AIMC_LVL_OFF);
  endfunction

  // a strobe that names one register; other offsets match nothing
  function automatic logic reg_hit(input logic strobe, input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] offset);
    reg_hit = strobe && (addr == offset);
  endfunction

  assign wr_aux_mic = reg_hit(reg_wr, reg_addr, ADDR_W'(`AIMC_OFF_AUX_MIC_RIGHT));
  assign wr_line = reg_hit(reg_wr, reg_addr, ADDR_W'(`AIMC_OFF_LINE_LEFT));
  assign rd_aux_mic = reg_hit(reg_rd, reg_addr, ADDR_W'(`AIMC_OFF_AUX_MIC_RIGHT));
  assign rd_line = reg_hit(reg_rd, reg_addr, ADDR_W'(`AIMC_OFF_LINE_LEFT));

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      aux_mic_to_right_adc_mix_ff <= `AIMC_RST_AUX_MIC_RIGHT;
    end else if (wr_aux_mic) begin
      // every code is stored, reserved ones too, so reads return what was written
      aux_mic_to_right_adc_mix_ff <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      line_in_left_adc_mix_power_ff <= `AIMC_RST_LINE_LEFT;
    end else if (wr_line) begin
      line_in_left_adc_mix_power_ff <= reg_wdata;
    end
  end

  // unmapped offsets read as zero
  always_comb begin
    if (rd_aux_mic) begin
      nxt_rdata = aux_mic_to_right_adc_mix_ff;
    end else if (rd_line) begin
      nxt_rdata = line_in_left_adc_mix_power_ff;
    end else begin
      nxt_rdata = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata_ff <= '0;
    end else if (reg_rd) begin
      // read data moves only on a read strobe and then stands
      reg_rdata_ff <= nxt_rdata;
    end
  end

  assign auxl_code = aux_mic_to_right_adc_mix_ff[`AIMC_AUXL_HI:`AIMC_AUXL_LO];
  assign auxr_code = aux_mic_to_right_adc_mix_ff[`AIMC_AUXR_HI:`AIMC_AUXR_LO];
  assign line_code = line_in_left_adc_mix_power_ff[`AIMC_LINE_HI:`AIMC_LINE_LO];
  assign step_code = line_in_left_adc_mix_power_ff[`AIMC_STEP_HI:`AIMC_STEP_LO];

  // decoded outputs trail their register by one cycle so each leaves a flop
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      aux_mic_left_input_conn_ff <= 1'b0;
    end else begin
      aux_mic_left_input_conn_ff <= lvl_conn(auxl_code);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      aux_mic_left_input_attn_ff <= `AIMC_RST_ATTN;
    end else begin
      aux_mic_left_input_attn_ff <= lvl_attn(auxl_code);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      aux_mic_right_input_conn_ff <= 1'b0;
    end else begin
      aux_mic_right_input_conn_ff <= lvl_conn(auxr_code);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      aux_mic_right_input_attn_ff <= `AIMC_RST_ATTN;
    end else begin
      aux_mic_right_input_attn_ff <= lvl_attn(auxr_code);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      first_line_left_input_conn_ff <= 1'b0;
    end else begin
      first_line_left_input_conn_ff <= lvl_conn(line_code);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      first_line_left_input_attn_ff <= `AIMC_RST_ATTN;
    end else begin
      first_line_left_input_attn_ff <= lvl_attn(line_code);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      first_line_left_input_diff_ff <= 1'b0;
    end else begin
      first_line_left_input_diff_ff <= line_in_left_adc_mix_power_ff[`AIMC_DIFF_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      left_adc_power_ff <= 1'b0;
    end else begin
      left_adc_power_ff <= line_in_left_adc_mix_power_ff[`AIMC_PWR_BIT];
    end
  end

  // rates 10 and 11 leave the applied gain tracking its target at once
  always_comb begin
    case (step_code)
      `AIMC_STEP_EVERY_FS: step_mode = aimc_pkg::AIMC_STEP_FS;
      `AIMC_STEP_EVERY_2FS: step_mode = aimc_pkg::AIMC_STEP_2FS;
      default: step_mode = aimc_pkg::AIMC_STEP_OFF;
    endcase
  end

  // the gain setting itself sits outside and arrives on the target port
  aimc_gain_step #(
    .GAIN_W(GAIN_W)
  ) u_gain_step (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .target_gain(left_gain_target),
    .step_mode(step_mode),
    .fs_tick(fs_tick),
    .gain_ff(left_gain_applied_ff)
  );

endmodule

// *** tb/aimc_regs_assertions.sv ***
// checker on the ports of the adc input mix register pair
module aimc_regs_chk (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_ff,
  input wire logic [6:0] left_gain_applied_ff,
  input wire logic aux_mic_left_input_conn_ff,
  input wire logic [4:0] aux_mic_left_input_attn_ff,
  input wire logic aux_mic_right_input_conn_ff,
  input wire logic [4:0] aux_mic_right_input_attn_ff,
  input wire logic first_line_left_input_conn_ff,
  input wire logic [4:0] first_line_left_input_attn_ff,
  input wire logic first_line_left_input_diff_ff,
  input wire logic left_adc_power_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire logic w12 = reg_wr && reg_addr == 8'h12;
  wire logic w13 = reg_wr && reg_addr == 8'h13;
  chk_auxl_cut: assert property (w12 && reg_wdata[7:4] == 4'hf |->
    ##2 !aux_mic_left_input_conn_ff) else $error("left aux mic still joined");
  chk_auxl_level: assert property (w12 && reg_wdata[7:4] <= 4'h8 |-> ##2
    aux_mic_left_input_conn_ff &&
    aux_mic_left_input_attn_ff == 3 * $past(reg_wdata[7:4], 2)) else $error("left aux level");
  chk_auxr_cut: assert property (w12 && reg_wdata[3:0] == 4'hf |->
    ##2 !aux_mic_right_input_conn_ff) else $error("right aux mic still joined");
  chk_auxr_join: assert property (w12 && reg_wdata[3:0] <= 4'h8 |->
    ##2 aux_mic_right_input_conn_ff) else $error("right aux mic not joined");
  chk_auxr_level: assert property (w12 && reg_wdata[3:0] <= 4'h8 |-> ##2
    aux_mic_right_input_attn_ff == 3 * $past(reg_wdata[3:0], 2)) else $error("right aux level");
  chk_diff_bit: assert property (w13 |->
    ##2 first_line_left_input_diff_ff == $past(reg_wdata[7], 2)) else $error("line config bit");
  chk_power_bit: assert property (w13 |->
    ##2 left_adc_power_ff == $past(reg_wdata[2], 2)) else $error("adc power bit");
  chk_line_cut: assert property (w13 && reg_wdata[6:3] == 4'hf |->
    ##2 !first_line_left_input_conn_ff) else $error("line input still joined");
  chk_line_level: assert property (w13 && reg_wdata[6:3] <= 4'h8 |-> ##2
    first_line_left_input_conn_ff &&
    first_line_left_input_attn_ff == 3 * $past(reg_wdata[6:3], 2)) else $error("line level");
  chk_reset_quiet: assert property ($fell(sys_rst) |->
    left_gain_applied_ff == 7'h00 && !left_adc_power_ff) else $error("outputs not at reset");
  chk_unmapped_rd: assert property (reg_rd && reg_addr != 8'h12 && reg_addr != 8'h13 |=>
    reg_rdata_ff == 8'h00) else $error("unmapped read data");
  cov_wr12: cover property (w12);
  cov_rd: cover property (reg_rd);
  cov_step: cover property ($changed(left_gain_applied_ff));
  cov_rerun: cover property ($fell(sys_rst));
endmodule
bind aimc_regs aimc_regs_chk chk_u (.*);

// *** tb/aimc_host.sv ***
// host model issuing register writes and reads
module aimc_host (
  input wire logic ref_clk,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  input wire logic [7:0] reg_rdata_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  // callers keep level codes to 0-8 or f and use both line configs
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge ref_clk) {reg_wr, reg_wdata} <= {1'b0, ~v};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk) reg_rd <= 1'b0;
    @(posedge ref_clk) #1 v = reg_rdata_ff;
  endtask
endmodule

// *** tb/adc_input_mix_control_regs_tb_top.sv ***
// testbench for the adc input mix register pair
`define CMP(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("BAD %0t value", $time); end end
module adc_input_mix_control_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic fs_tick = 1'b0;
  logic [6:0] tgt = 7'h00;
  logic [7:0] ad, wd, rdat, d;
  logic wr, rd, lc, rc, nc, df, pw;
  logic [4:0] la, ra, na;
  logic [6:0] g;
  int n_mismatch = 0;
  int checks = 0;
  always #2 ref_clk = ~ref_clk;
  aimc_host host_u (.ref_clk(ref_clk), .reg_addr(ad), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata_ff(rdat));
  aimc_regs dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(ad), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata_ff(rdat), .left_gain_target(tgt), .fs_tick(fs_tick),
    .left_gain_applied_ff(g), .aux_mic_left_input_conn_ff(lc), .aux_mic_left_input_attn_ff(la),
    .aux_mic_right_input_conn_ff(rc), .aux_mic_right_input_attn_ff(ra),
    .first_line_left_input_conn_ff(nc), .first_line_left_input_attn_ff(na),
    .first_line_left_input_diff_ff(df), .left_adc_power_ff(pw));
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic tick();
    @(posedge ref_clk) fs_tick <= 1'b1;
    @(posedge ref_clk) fs_tick <= 1'b0;
    #1;
  endtask
  task automatic t_reset();
    host_u.rd(8'h12, d);
    `CMP(d, 8'hff)
    host_u.rd(8'h13, d);
    `CMP(d, 8'h78)
    `CMP({lc, rc, nc, df, pw}, 5'h00)
    $display("t_reset done");
  endtask
  task automatic t_levels();
    logic [3:0] c, r;
    for (int i = 0; i < 10; i++) begin
      c = (i == 9) ? 4'hf : 4'(i);
      r = (i == 9) ? 4'hf : 4'(8 - i);
      host_u.wr(8'h12, {c, r});
      settle();
      `CMP({lc, la}, (c == 4'hf) ? 6'h00 : {1'b1, 5'(3 * c)})
      `CMP({rc, ra}, (r == 4'hf) ? 6'h00 : {1'b1, 5'(3 * r)})
    end
    $display("t_levels done");
  endtask
  task automatic t_line();
    host_u.wr(8'h13, 8'h84);
    settle();
    `CMP({df, pw, nc, na}, 8'he0)
    host_u.wr(8'h13, 8'h40);
    host_u.wr(8'h14, 8'h00);
    settle();
    `CMP({df, pw, nc, na}, 8'h38)
    host_u.rd(8'h13, d);
    `CMP(d, 8'h40)
    host_u.rd(8'h14, d);
    `CMP(d, 8'h00)
    $display("t_line done");
  endtask
  task automatic t_step();
    @(posedge ref_clk) tgt <= 7'h03;
    settle();
    `CMP(g, 7'h00)
    tick();
    `CMP(g, 7'h01)
    tick();
    `CMP(g, 7'h02)
    host_u.wr(8'h13, 8'h7a);
    settle();
    `CMP(g, 7'h03)
    host_u.wr(8'h13, 8'h79);
    @(posedge ref_clk) tgt <= 7'h01;
    tick();
    `CMP(g, 7'h03)
    tick();
    `CMP(g, 7'h02)
    $display("t_step done");
  endtask
  task automatic t_rerun();
    host_u.wr(8'h12, 8'h00);
    host_u.wr(8'h13, 8'h87);
    host_u.rd(8'h13, d);
    `CMP(d, 8'h87)
    `CMP({lc, rc, df, pw}, 4'hf)
    @(posedge ref_clk) sys_rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    host_u.rd(8'h12, d);
    `CMP(d, 8'hff)
    host_u.rd(8'h13, d);
    `CMP(d, 8'h78)
    `CMP({lc, la, rc, ra, nc, na, df, pw, g}, 27'h0)
    $display("t_rerun done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_levels();
    t_line();
    t_step();
    t_rerun();
    close_out();
  end
  initial begin
    #20000;
    n_mismatch++;
    close_out();
  end
endmodule
